// File: core_defs.svh
// constants for the 8-bit instruction timing core
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
`define PHASES 4
`define PH_OPND 2'h1
`define PH_SAMPLE 2'h2
`define PH_COMMIT 2'h3
`define PC_W 10
`define DA_W 7
`define IW 16
`define OP_HI 15
`define OP_LO 10
`define BIT_HI 9
`define BIT_LO 7
`define PG_HI 9
`define PG_LO 8
`define PCL_ADDR 7'h02
`define STACK_DEPTH 8
`define PC_RESET 10'h000
`define BYTE_MAX 9'h0FF
`endif

// File: isa_pkg.sv
// types for the 8-bit instruction timing core
package isa_pkg;
    typedef enum logic [5:0] {
        op_nop, op_load_acc, op_store_acc, op_load_imm,
        op_add, op_add_to_mem, op_add_imm, op_add_carry,
        op_sub, op_sub_to_mem, op_sub_imm, op_sub_carry,
        op_and, op_and_to_mem, op_and_imm, op_or, op_or_imm, op_xor, op_xor_imm,
        op_complement, op_complement_acc, op_inc, op_inc_acc, op_sub_one, op_sub_one_acc,
        op_rot_right, op_rot_right_acc, op_rot_left, op_rot_left_acc,
        op_rot_right_carry, op_rot_left_carry, op_bit_set, op_bit_force_low,
        op_skip_zero, op_skip_zero_acc, op_skip_bit_low, op_skip_bit_high,
        op_skip_inc_zero, op_skip_dec_zero,
        op_branch, op_call, op_exit, op_int_exit, op_table_read, op_halt
    } op_t;
    typedef enum logic [3:0] {
        fn_pass_a, fn_pass_b, fn_add, fn_sub, fn_and, fn_or, fn_xor, fn_not,
        fn_inc, fn_minus1, fn_ror, fn_rol, fn_rorc, fn_rolc, fn_setb, fn_clrb
    } alu_fn_t;
    typedef enum logic [1:0] {cin_zero, cin_one, cin_carry} cin_sel_t;
    typedef struct packed {
        alu_fn_t fn;
        cin_sel_t cin;
        logic use_imm;
        logic wr_mem;
        logic wr_acc;
        logic set_c;
        logic set_z;
    } decode_t;
    typedef enum {st_run, st_halt} run_state_t;
endpackage : isa_pkg

// File: alu_if.sv
// operand and result bundle between sequencer and alu
interface alu_if;
    isa_pkg::alu_fn_t fn;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] bit_idx;
    logic cin;
    logic [7:0] y;
    logic cout;
    logic zero;
    modport user (output fn, a, b, bit_idx, cin, input y, cout, zero);
    modport alu (input fn, a, b, bit_idx, cin, output y, cout, zero);
endinterface : alu_if

// File: core_alu.sv
// combinational 8-bit alu
module core_alu (
    // operands and result
    alu_if.alu bus
);
    logic [8:0] s;
    always_comb begin
        s = 9'h000;
        bus.y = 8'h00;
        bus.cout = bus.cin;
        case (bus.fn)
            isa_pkg::fn_pass_a: bus.y = bus.a;
            isa_pkg::fn_pass_b: bus.y = bus.b;
            isa_pkg::fn_add: begin
                s = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
                bus.y = s[7:0];
                bus.cout = s[8];
            end
            // carry out high means no borrow
            isa_pkg::fn_sub: begin
                s = {1'b0, bus.a} + {1'b0, ~bus.b} + {8'h00, bus.cin};
                bus.y = s[7:0];
                bus.cout = s[8];
            end
            isa_pkg::fn_and: bus.y = bus.a & bus.b;
            isa_pkg::fn_or: bus.y = bus.a | bus.b;
            isa_pkg::fn_xor: bus.y = bus.a ^ bus.b;
            isa_pkg::fn_not: bus.y = ~bus.b;
            isa_pkg::fn_inc: bus.y = bus.b + 8'h01;
            isa_pkg::fn_minus1: bus.y = bus.b - 8'h01;
            isa_pkg::fn_ror: bus.y = {bus.b[0], bus.b[7:1]};
            isa_pkg::fn_rol: bus.y = {bus.b[6:0], bus.b[7]};
            isa_pkg::fn_rorc: begin
                bus.y = {bus.cin, bus.b[7:1]};
                bus.cout = bus.b[0];
            end
            isa_pkg::fn_rolc: begin
                bus.y = {bus.b[6:0], bus.cin};
                bus.cout = bus.b[7];
            end
            isa_pkg::fn_setb: bus.y = bus.b | (8'h01 << bus.bit_idx);
            isa_pkg::fn_clrb: bus.y = bus.b & ~(8'h01 << bus.bit_idx);
            default: bus.y = 8'h00;
        endcase
    end
    assign bus.zero = (bus.y == 8'h00);
endmodule : core_alu

// File: core_stack.sv
// return address stack
`include "core_defs.svh"
module core_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int W = `PC_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // push and pop
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] push_data,
    output logic [W-1:0] top
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] sp_q;
    // overflow wraps silently, oldest entry is lost
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sp_q <= '0;
        end else if (push) begin
            sp_q <= sp_q + PW'(1);
        end else if (pop) begin
            sp_q <= sp_q - PW'(1);
        end
    end
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[sp_q] <= push_data;
        end
    end
    assign top = mem_q[sp_q - PW'(1)];
endmodule : core_stack

// File: mcu_instruction_timing_core.sv
// instruction sequencer and datapath of the 8-bit core
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - one instruction cycle is four clocks
// - ordinary instructions finish in one cycle
// - branch, call, returns, table read take two
// - writing program counter low byte jumps, costs one
// - taken skip costs one extra cycle
// - add carries above 255, subtract borrows below 0
// - increment and decrement change operand by one
// - logic results set zero flag when zero
// - rotates shift one bit, carry variants through carry
// - call saves next address, return resumes there
// - branch loads target, saves no return address
// - conditional tests skip or execute next instruction
// - bit set and clear touch one bit
// - program memory serves as a data table
// - three transfer forms through the accumulator
// - accumulator is one operand of manipulation
// - halt enters power-down
////////////////////////////////////////////////////////////////////////////////
`include "core_defs.svh"
module mcu_instruction_timing_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // program memory, one-cycle registered read
    output logic [`PC_W-1:0] pm_addr,
    input wire logic [`IW-1:0] pm_rdata,
    // data memory
    output logic [`DA_W-1:0] dm_addr,
    output logic dm_we,
    output logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    // power-down
    input wire logic wake_pin,
    output logic halted,
    // status
    output logic [7:0] acc,
    output logic carry_flag,
    output logic zero_flag,
    output logic retire
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] ph_q;
    logic [`IW-1:0] ir_q;
    logic [`IW-1:0] fetch_q;
    logic ir_valid_q;
    logic [`PC_W-1:0] pc_q;
    logic [`PC_W-1:0] next_pc;
    logic [7:0] opnd_q;
    logic wake_s1_q;
    logic wake_s2_q;
    isa_pkg::run_state_t state_q;
    isa_pkg::op_t op;
    isa_pkg::decode_t d;
    logic live;
    logic commit;
    logic skip_now;
    logic pcl_write;
    logic flush;
    logic [`PC_W-1:0] stack_top;

    function automatic isa_pkg::decode_t decode(isa_pkg::op_t o);
        isa_pkg::decode_t r;
        r = '{fn: isa_pkg::fn_pass_b, cin: isa_pkg::cin_zero, default: 1'b0};
        case (o)
            isa_pkg::op_store_acc: r.fn = isa_pkg::fn_pass_a;
            isa_pkg::op_add, isa_pkg::op_add_to_mem, isa_pkg::op_add_imm: begin
                r.fn = isa_pkg::fn_add;
            end
            isa_pkg::op_add_carry: begin
                r.fn = isa_pkg::fn_add;
                r.cin = isa_pkg::cin_carry;
            end
            isa_pkg::op_sub, isa_pkg::op_sub_to_mem, isa_pkg::op_sub_imm: begin
                r.fn = isa_pkg::fn_sub;
                r.cin = isa_pkg::cin_one;
            end
            isa_pkg::op_sub_carry: begin
                r.fn = isa_pkg::fn_sub;
                r.cin = isa_pkg::cin_carry;
            end
            isa_pkg::op_and, isa_pkg::op_and_to_mem, isa_pkg::op_and_imm: begin
                r.fn = isa_pkg::fn_and;
            end
            isa_pkg::op_or, isa_pkg::op_or_imm: r.fn = isa_pkg::fn_or;
            isa_pkg::op_xor, isa_pkg::op_xor_imm: r.fn = isa_pkg::fn_xor;
            isa_pkg::op_complement, isa_pkg::op_complement_acc: r.fn = isa_pkg::fn_not;
            isa_pkg::op_inc, isa_pkg::op_inc_acc, isa_pkg::op_skip_inc_zero: begin
                r.fn = isa_pkg::fn_inc;
            end
            isa_pkg::op_sub_one, isa_pkg::op_sub_one_acc, isa_pkg::op_skip_dec_zero: begin
                r.fn = isa_pkg::fn_minus1;
            end
            isa_pkg::op_rot_right, isa_pkg::op_rot_right_acc: r.fn = isa_pkg::fn_ror;
            isa_pkg::op_rot_left, isa_pkg::op_rot_left_acc: r.fn = isa_pkg::fn_rol;
            isa_pkg::op_rot_right_carry: begin
                r.fn = isa_pkg::fn_rorc;
                r.cin = isa_pkg::cin_carry;
            end
            isa_pkg::op_rot_left_carry: begin
                r.fn = isa_pkg::fn_rolc;
                r.cin = isa_pkg::cin_carry;
            end
            isa_pkg::op_bit_set: r.fn = isa_pkg::fn_setb;
            isa_pkg::op_bit_force_low: r.fn = isa_pkg::fn_clrb;
            default: r.fn = isa_pkg::fn_pass_b;
        endcase
        r.use_imm = o inside {isa_pkg::op_load_imm, isa_pkg::op_add_imm,
            isa_pkg::op_sub_imm, isa_pkg::op_and_imm, isa_pkg::op_or_imm,
            isa_pkg::op_xor_imm};
        r.wr_mem = o inside {isa_pkg::op_store_acc, isa_pkg::op_add_to_mem,
            isa_pkg::op_sub_to_mem, isa_pkg::op_and_to_mem, isa_pkg::op_complement,
            isa_pkg::op_inc, isa_pkg::op_sub_one, isa_pkg::op_rot_right,
            isa_pkg::op_rot_left, isa_pkg::op_rot_right_carry,
            isa_pkg::op_rot_left_carry, isa_pkg::op_bit_set,
            isa_pkg::op_bit_force_low, isa_pkg::op_skip_inc_zero,
            isa_pkg::op_skip_dec_zero};
        r.wr_acc = o inside {isa_pkg::op_load_acc, isa_pkg::op_load_imm,
            isa_pkg::op_add, isa_pkg::op_add_imm, isa_pkg::op_add_carry,
            isa_pkg::op_sub, isa_pkg::op_sub_imm, isa_pkg::op_sub_carry,
            isa_pkg::op_and, isa_pkg::op_and_imm, isa_pkg::op_or,
            isa_pkg::op_or_imm, isa_pkg::op_xor, isa_pkg::op_xor_imm,
            isa_pkg::op_complement_acc, isa_pkg::op_inc_acc,
            isa_pkg::op_sub_one_acc, isa_pkg::op_rot_right_acc,
            isa_pkg::op_rot_left_acc, isa_pkg::op_skip_zero_acc};
        r.set_c = r.fn inside {isa_pkg::fn_add, isa_pkg::fn_sub,
            isa_pkg::fn_rorc, isa_pkg::fn_rolc};
        r.set_z = r.fn inside {isa_pkg::fn_add, isa_pkg::fn_sub, isa_pkg::fn_and,
            isa_pkg::fn_or, isa_pkg::fn_xor, isa_pkg::fn_not} ||
            o inside {isa_pkg::op_inc, isa_pkg::op_inc_acc,
            isa_pkg::op_sub_one, isa_pkg::op_sub_one_acc};
        return r;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////
    assign op = isa_pkg::op_t'(ir_q[`OP_HI:`OP_LO]);
    assign d = decode(op);
    assign live = ir_valid_q && (state_q == isa_pkg::st_run);
    assign commit = (ph_q == `PH_COMMIT);

    alu_if au();
    core_alu u_alu (
        .bus(au)
    );

    assign au.fn = d.fn;
    assign au.a = acc;
    assign au.b = d.use_imm ? ir_q[7:0] : opnd_q;
    assign au.bit_idx = ir_q[`BIT_HI:`BIT_LO];

    always_comb begin
        case (d.cin)
            isa_pkg::cin_one: au.cin = 1'b1;
            isa_pkg::cin_carry: au.cin = carry_flag;
            default: au.cin = 1'b0;
        endcase
    end

    core_stack u_stack (
        .core_clk(core_clk),
        .rstn(rstn),
        .push(commit && live && (op == isa_pkg::op_call)),
        .pop(commit && live && op inside {isa_pkg::op_exit, isa_pkg::op_int_exit}),
        .push_data(pc_q),
        .top(stack_top)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (op)
            isa_pkg::op_skip_zero: skip_now = (opnd_q == 8'h00);
            isa_pkg::op_skip_zero_acc: skip_now = (opnd_q == 8'h00);
            isa_pkg::op_skip_bit_low: skip_now = !opnd_q[au.bit_idx];
            isa_pkg::op_skip_bit_high: skip_now = opnd_q[au.bit_idx];
            isa_pkg::op_skip_inc_zero: skip_now = au.zero;
            isa_pkg::op_skip_dec_zero: skip_now = au.zero;
            default: skip_now = 1'b0;
        endcase
    end

    assign pcl_write = d.wr_mem && (ir_q[`DA_W-1:0] == `PCL_ADDR);
    // the word fetched alongside a redirecting instruction is thrown away
    assign flush = live && (skip_now || pcl_write || op inside {isa_pkg::op_branch,
        isa_pkg::op_call, isa_pkg::op_exit, isa_pkg::op_int_exit,
        isa_pkg::op_table_read, isa_pkg::op_halt});

    always_comb begin
        next_pc = pc_q + `PC_W'(1);
        if (state_q == isa_pkg::st_halt) begin
            next_pc = pc_q;
        end else if (ir_valid_q) begin
            case (op)
                isa_pkg::op_branch: next_pc = ir_q[`PC_W-1:0];
                isa_pkg::op_call: next_pc = ir_q[`PC_W-1:0];
                isa_pkg::op_exit: next_pc = stack_top;
                isa_pkg::op_int_exit: next_pc = stack_top;
                isa_pkg::op_table_read: next_pc = pc_q;
                isa_pkg::op_halt: next_pc = pc_q;
                default: begin
                    if (pcl_write) begin
                        next_pc = {pc_q[`PC_W-1:8], au.y};
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ph_q <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
        end
    end

    // fetch and program counter; a flushed cycle runs as a bubble
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= `PC_RESET;
            pm_addr <= `PC_RESET;
            ir_q <= 16'h0000;
            ir_valid_q <= 1'b0;
            dm_addr <= 7'h00;
        end else if (commit) begin
            pc_q <= next_pc;
            pm_addr <= next_pc;
            ir_q <= fetch_q;
            ir_valid_q <= live ? !flush : (state_q == isa_pkg::st_run);
            dm_addr <= fetch_q[`DA_W-1:0];
        end else if (ph_q == 2'h0 && live && op == isa_pkg::op_table_read) begin
            pm_addr <= {ir_q[`PG_HI:`PG_LO], acc};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fetch_q <= 16'h0000;
        end else if (ph_q == `PH_SAMPLE) begin
            fetch_q <= pm_rdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            opnd_q <= 8'h00;
        end else if (ph_q == `PH_OPND) begin
            opnd_q <= dm_rdata;
        end
    end

    // write-back is internal read-modify-write of the whole byte
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dm_we <= 1'b0;
            dm_wdata <= 8'h00;
        end else if (ph_q == `PH_SAMPLE) begin
            dm_we <= live && d.wr_mem;
            dm_wdata <= au.y;
        end else begin
            dm_we <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acc <= 8'h00;
            carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else if (commit && live) begin
            if (op == isa_pkg::op_table_read) begin
                acc <= fetch_q[7:0];
            end else if (d.wr_acc) begin
                acc <= au.y;
            end
            if (d.set_c) begin
                carry_flag <= au.cout;
            end
            if (d.set_z) begin
                zero_flag <= au.zero;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake is a pin, so it is synchronised before use
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end else begin
            wake_s1_q <= wake_pin;
            wake_s2_q <= wake_s1_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= isa_pkg::st_run;
        end else if (commit) begin
            case (state_q)
                isa_pkg::st_run: begin
                    if (live && op == isa_pkg::op_halt) begin
                        state_q <= isa_pkg::st_halt;
                    end
                end
                isa_pkg::st_halt: begin
                    if (wake_s2_q) begin
                        state_q <= isa_pkg::st_run;
                    end
                end
                default: state_q <= isa_pkg::st_run;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            halted <= 1'b0;
            retire <= 1'b0;
        end else begin
            halted <= (state_q == isa_pkg::st_halt);
            retire <= commit && live;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    phase_wrap_a: assert property (ph_q == `PH_COMMIT |=> ph_q == 2'h0)
        else $error("phase counter did not wrap after four clocks");
    retire_spacing_a: assert property (retire |=> !retire [*3])
        else $error("instructions retired closer than one instruction cycle");
    single_cycle_a: assert property (commit && live && !flush |=> ir_valid_q)
        else $error("plain instruction inserted a bubble");
    // the target is checked once, at the first bubble clock, before ir_q refills
    branch_bubble_a: assert property (commit && live && op == isa_pkg::op_branch
        |=> (pc_q == $past(ir_q[`PC_W-1:0])) ##0 (!ir_valid_q [*4]) ##1 ir_valid_q)
        else $error("branch did not load target with exactly one bubble");
    pcl_jump_a: assert property (commit && live && pcl_write
        |=> !ir_valid_q && pc_q[7:0] == $past(dm_wdata))
        else $error("low byte write did not jump");
    skip_extra_a: assert property (commit && live && skip_now
        |=> !ir_valid_q && pc_q == $past(pc_q) + `PC_W'(1))
        else $error("taken skip did not discard the next instruction");
    add_carry_a: assert property (commit && live && op inside {isa_pkg::op_add, isa_pkg::op_add_imm}
        |=> carry_flag == (({1'b0, $past(acc)} + {1'b0, $past(au.b)}) > `BYTE_MAX))
        else $error("add carry wrong");
    logic_zero_a: assert property (commit && live && op inside {isa_pkg::op_and,
        isa_pkg::op_and_imm, isa_pkg::op_or_imm, isa_pkg::op_xor_imm}
        |=> zero_flag == (acc == 8'h00))
        else $error("logic zero flag wrong");
    call_save_a: assert property (commit && live && op == isa_pkg::op_call
        |=> stack_top == $past(pc_q))
        else $error("call did not save the following address");
    bit_only_a: assert property (dm_we && op == isa_pkg::op_bit_set
        |-> dm_wdata == (opnd_q | (8'h01 << au.bit_idx)))
        else $error("bit set touched other bits");
    halt_entry_a: assert property (commit && live && op == isa_pkg::op_halt
        |=> state_q == isa_pkg::st_halt ##1 halted)
        else $error("halt did not enter power-down");
endmodule : mcu_instruction_timing_core

// File: prog_data_mem.sv
// program and data memory model facing the core
`include "core_defs.svh"
module prog_data_mem (
    // clock
    input wire logic core_clk,
    // program memory
    input wire logic [`PC_W-1:0] pm_addr,
    output logic [`IW-1:0] pm_rdata,
    // data memory
    input wire logic [`DA_W-1:0] dm_addr,
    input wire logic dm_we,
    input wire logic [7:0] dm_wdata,
    output logic [7:0] dm_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`IW-1:0] pm [0:(1<<`PC_W)-1];
    logic [7:0] dm [0:(1<<`DA_W)-1];
    ////////////////////////////////////////////////////////////
    // registered read, as a real on-chip memory would be
    always @(posedge core_clk) begin
        pm_rdata <= pm[pm_addr];
    end
    // unwritten places read as x, so the bench clears every byte
    assign dm_rdata = dm[dm_addr];
    always @(posedge core_clk) begin
        if (dm_we) begin
            dm[dm_addr] <= dm_wdata;
        end
    end
endmodule : prog_data_mem

// File: mcu_instruction_timing_core_tb.sv
// self-checking bench for the instruction timing core
`include "core_defs.svh"
module mcu_instruction_timing_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic wake_pin = 1'b0;
    logic [`PC_W-1:0] pm_addr;
    logic [`IW-1:0] pm_rdata;
    logic [`DA_W-1:0] dm_addr;
    logic dm_we, halted, carry_flag, zero_flag, retire;
    logic [7:0] dm_wdata, dm_rdata, acc;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int last, mpc, macc, mc, mz, ex, op;
    int mdm [128];
    int stk [$];
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    // ceiling well above three runs of about 180 clocks each
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count++;
            wrap_up();
        end
    end
    mcu_instruction_timing_core dut_u (.core_clk(core_clk), .rstn(rstn), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_we(dm_we), .dm_wdata(dm_wdata),
        .dm_rdata(dm_rdata), .wake_pin(wake_pin), .halted(halted), .acc(acc),
        .carry_flag(carry_flag), .zero_flag(zero_flag), .retire(retire));
    prog_data_mem mem_u (.core_clk(core_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_we(dm_we), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
    ////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_cyc(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            fail_count++;
            $display("ERROR at %0t: clocks %h expected %h", $time, got, exp);
        end
    endtask : chk_cyc
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic put(input int a, input isa_pkg::op_t o, input int f);
        mem_u.pm[a] = {6'(o), 10'(f)};
    endtask : put
    task automatic load_prog();
        for (int i = 0; i < 32; i++) put(i, isa_pkg::op_nop, $urandom_range(255));
        put(0, isa_pkg::op_load_imm, $urandom_range(255));
        put(1, isa_pkg::op_add_imm, $urandom_range(255));
        put(2, isa_pkg::op_store_acc, 'h10);
        put(3, isa_pkg::op_sub_imm, $urandom_range(255));
        put(4, isa_pkg::op_and_imm, $urandom_range(255));
        put(5, isa_pkg::op_or_imm, $urandom_range(255));
        put(6, isa_pkg::op_xor_imm, $urandom_range(255));
        put(7, isa_pkg::op_bit_set, 'h190);
        put(8, isa_pkg::op_bit_force_low, 'h10);
        put(9, isa_pkg::op_load_acc, 'h10);
        put(10, isa_pkg::op_inc_acc, 'h10);
        put(11, isa_pkg::op_rot_left_carry, 'h10);
        put(12, isa_pkg::op_skip_zero, 'h11);
        put(14, isa_pkg::op_skip_zero, 'h10);
        put(15, isa_pkg::op_call, 20);
        put(16, isa_pkg::op_branch, 22);
        put(20, isa_pkg::op_load_imm, 'h55);
        put(21, isa_pkg::op_exit, 0);
        put(22, isa_pkg::op_load_imm, 31);
        put(23, isa_pkg::op_table_read, 0);
        put(24, isa_pkg::op_load_imm, 27);
        put(25, isa_pkg::op_store_acc, `PCL_ADDR);
        put(27, isa_pkg::op_load_acc, 'h10);
        put(28, isa_pkg::op_halt, 0);
        put(29, isa_pkg::op_load_imm, $urandom_range(255));
        put(30, isa_pkg::op_branch, 30);
    endtask : load_prog
    // reference model: one call per retired instruction
    task automatic step();
        logic [`IW-1:0] w;
        int m, v, t;
        w = mem_u.pm[mpc];
        op = int'(w[`OP_HI:`OP_LO]);
        m = int'(w[6:0]);
        v = int'(w[7:0]);
        ex = 0;
        mpc++;
        case (op)
            isa_pkg::op_load_imm: macc = v;
            isa_pkg::op_load_acc: macc = mdm[m];
            isa_pkg::op_add_imm: t = macc + v;
            isa_pkg::op_sub_imm: t = macc - v;
            isa_pkg::op_and_imm: t = macc & v;
            isa_pkg::op_or_imm: t = macc | v;
            isa_pkg::op_xor_imm: t = macc ^ v;
            isa_pkg::op_inc_acc: t = mdm[m] + 1;
            isa_pkg::op_bit_set: mdm[m] |= 1 << w[`BIT_HI:`BIT_LO];
            isa_pkg::op_bit_force_low: mdm[m] &= ~(1 << w[`BIT_HI:`BIT_LO]);
            isa_pkg::op_table_read: begin
                macc = mem_u.pm[{w[`PG_HI:`PG_LO], 8'(macc)}] & 255;
                ex = 1;
            end
            isa_pkg::op_rot_left_carry: begin
                t = mdm[m];
                mdm[m] = ((t << 1) | mc) & 255;
                mc = t >> 7;
            end
            isa_pkg::op_store_acc: begin
                mdm[m] = macc;
                ex = int'(m == `PCL_ADDR);
                if (ex == 1) mpc = (mpc & 'h300) | macc;
            end
            isa_pkg::op_skip_zero: begin
                ex = int'(mdm[m] == 0);
                mpc += ex;
            end
            isa_pkg::op_call: stk.push_back(mpc);
            default: ;
        endcase
        if (op inside {isa_pkg::op_call, isa_pkg::op_branch}) mpc = int'(w[9:0]);
        if (op inside {isa_pkg::op_call, isa_pkg::op_branch, isa_pkg::op_halt}) ex = 1;
        if (op == isa_pkg::op_exit) begin
            mpc = stk.pop_back();
            ex = 1;
        end
        if (op inside {[isa_pkg::op_add_imm:isa_pkg::op_xor_imm], isa_pkg::op_inc_acc}) begin
            if (op inside {isa_pkg::op_add_imm, isa_pkg::op_sub_imm}) mc = int'(t > 255 || t >= 0 && op == isa_pkg::op_sub_imm);
            macc = t & 255;
            mz = int'(macc == 0);
        end
    endtask : step
    initial begin
        void'($urandom(46936));
        for (int run = 0; run < 3; run++) begin
            @(posedge core_clk);
            #1 rstn = 1'b0;
            for (int i = 0; i < 128; i++) begin
                mem_u.dm[i] = 8'h00;
                mdm[i] = 0;
            end
            load_prog();
            repeat (6) @(posedge core_clk);
            chk_val({7'h00, halted}, 8'h00);
            #1 rstn = 1'b1;
            mpc = 0;
            macc = 0;
            mc = 0;
            mz = 0;
            ex = 0;
            last = -1;
            stk.delete();
            repeat (28) begin
                do @(negedge core_clk); while (retire !== 1'b1);
                if (last >= 0) chk_cyc(cyc - last, 4 * (1 + ex));
                last = cyc;
                step();
                chk_val(acc, 8'(macc));
                chk_val({6'h00, carry_flag, zero_flag}, 8'({mc[0], mz[0]}));
                if (wake_pin) begin
                    @(posedge core_clk);
                    #1 wake_pin = 1'b0;
                end
                if (op == isa_pkg::op_halt) begin
                    repeat (12) @(posedge core_clk);
                    chk_val({7'h00, halted}, 8'h01);
                    #1 wake_pin = 1'b1;
                    last = -1;
                end
            end
            $display("run %0d done", run);
        end
        wrap_up();
    end
endmodule : mcu_instruction_timing_core_tb
